// [hw/bridge_spi_ctrl.v]
// serial slave and fault control of a ten-bridge output driver
// assumes pins and sensor levels are asynchronous to clk_sys_i
//
// Summary of operation
// - power-on reset clears state, outputs off
// - sleep low: outputs off, registers reset
// - load undervoltage: outputs off, flag, auto restart
// - load overvoltage: outputs off, flag unlatched
// - logic undervoltage: ignore serial, initialise, tristate
// - thermal warning flag follows sensor, unlatched
// - thermal shutdown latches outputs off until clear
// - filtered overcurrent turns switch off, latched
// - filtered low-side open load latches flag
// - open-load shutdown disables output when enabled
// - never both switches on; dead time
// - cross-current turns both off, sets overcurrent
// - 16-bit word in, status out, MSB first
// - select fall loads current status
// - select rise executes word, tristates output
// - control word holds until replaced
// - frames are multiples of eight bits
// - address frame, data returned next frame
// - bank zero addressed after reset
// - clear runs after the next transmission
// - bit 15 clear, bit 14 bank select
// - bit 13 open-load shutdown for bank
// - activate bit high drives, low tristates
`timescale 1ns/1ps
`include "bridge_ctrl_regs.vh"

module bridge_spi_ctrl #(
	parameter DEAD_CYC = `DEAD_CYCLES,
	parameter OC_CYC = `OC_DELAY_CYCLES,
	parameter OL_CYC = `OL_DELAY_CYCLES
) (
	input wire clk_sys_i,
	input wire rst_i, // logic-supply power-on reset
	input wire sleep_control_input_i, // low = sleep
	input wire logic_uv_i, // logic supply below threshold
	input wire load_uv_i, // load supply undervoltage
	input wire load_ov_i, // load supply overvoltage
	input wire temp_warn_i, // any sensor at warning level
	input wire temp_sd_i, // any sensor at shutdown level
	input wire [9:0] oc_i, // per-bridge overcurrent
	input wire [9:0] ol_i, // per-bridge low-side open load
	input wire [9:0] cross_i, // per-bridge cross-current
	input wire sclk_i,
	input wire csn_i,
	input wire sdi_i,
	output reg sdo_o,
	output reg sdo_oe_n_o, // low while driving
	output reg [9:0] hs_on_o,
	output reg [9:0] ls_on_o,
	output reg supply_fail_flag_o,
	output reg thermal_warning_flag_o
);
	// ****************************************
	// input synchronisers
	// ****************************************
	reg [2:0] sclk_s_r; // [0] first stage, [2] edge history
	reg [2:0] csn_s_r;
	reg [1:0] sdi_s_r;
	reg [1:0] slp_s_r;
	reg [1:0] luv_s_r;
	reg [1:0] uv_s_r;
	reg [1:0] ov_s_r;
	reg [1:0] tw_s_r;
	reg [1:0] tsd_s_r;
	reg [9:0] oc_a_r;
	reg [9:0] oc_b_r;
	reg [9:0] ol_a_r;
	reg [9:0] ol_b_r;
	reg [9:0] cr_a_r;
	reg [9:0] cr_b_r;

	// sync chains: logic reads the second stage, and also the third for the sclk and csn edges
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sclk_s_r <= 3'h0;
			csn_s_r <= 3'h7;
			sdi_s_r <= 2'h0;
			slp_s_r <= 2'h0;
			luv_s_r <= 2'h3;
			uv_s_r <= 2'h0;
			ov_s_r <= 2'h0;
			tw_s_r <= 2'h0;
			tsd_s_r <= 2'h0;
			oc_a_r <= 10'h000;
			oc_b_r <= 10'h000;
			ol_a_r <= 10'h000;
			ol_b_r <= 10'h000;
			cr_a_r <= 10'h000;
			cr_b_r <= 10'h000;
		end
		else
		begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_i};
			csn_s_r <= {csn_s_r[1:0], csn_i};
			sdi_s_r <= {sdi_s_r[0], sdi_i};
			slp_s_r <= {slp_s_r[0], sleep_control_input_i};
			luv_s_r <= {luv_s_r[0], logic_uv_i};
			uv_s_r <= {uv_s_r[0], load_uv_i};
			ov_s_r <= {ov_s_r[0], load_ov_i};
			tw_s_r <= {tw_s_r[0], temp_warn_i};
			tsd_s_r <= {tsd_s_r[0], temp_sd_i};
			oc_a_r <= oc_i;
			oc_b_r <= oc_a_r;
			ol_a_r <= ol_i;
			ol_b_r <= ol_a_r;
			cr_a_r <= cross_i;
			cr_b_r <= cr_a_r;
		end
	end

	// ****************************************
	// derived events
	// ****************************************
	wire init_w; // digital initialisation request
	wire sclk_fall;
	wire cs_fall;
	wire cs_rise;
	wire cs_act;

	assign init_w = !slp_s_r[1] || luv_s_r[1];
	assign sclk_fall = !sclk_s_r[1] && sclk_s_r[2];
	assign cs_fall = !csn_s_r[1] && csn_s_r[2];
	assign cs_rise = csn_s_r[1] && !csn_s_r[2];
	assign cs_act = !csn_s_r[1];

	// ****************************************
	// control state
	// ****************************************
	reg [15:0] shift_r; // serial shift register
	reg [7:0] bit_cnt_r; // bits clocked this frame, mod 8 kept in [2:0]
	reg [15:0] ctrl0_r; // bank 0 control word
	reg [15:0] ctrl1_r; // bank 1 control word
	reg addr_r; // bank returned in next frame
	reg clr_pend_r; // clear awaiting the next transmission
	reg clr_bank_r; // bank the pending clear applies to
	reg [1:0] clear_r; // per-bank one-cycle clear
	reg tsd_latch_r; // thermal shutdown latched
	wire [9:0] oc_flags;
	wire [9:0] ol_flags;
	wire [9:0] hs_w;
	wire [9:0] ls_w;
	wire [9:0] active_w;
	wire [9:0] level_w;
	wire [9:0] olsd_w;
	wire [9:0] clr_w;
	wire allow_w;

	// status word for a bank, flags aligned low
	function [15:0] status_word;
		input bank;
		input sup;
		input tw;
		input tsd;
		input [9:0] ocf;
		input [9:0] olf;
		begin
			status_word = 16'h0000;
			status_word[`SW_SUPPLY_BIT] = sup;
			status_word[`SW_BANK_BIT] = bank;
			status_word[`SW_TWARN_BIT] = tw;
			status_word[`SW_TSD_BIT] = tsd;
			if (bank)
			begin
				status_word[`SW_OC_LSB +: 6] = {2'h0, ocf[9:6]};
				status_word[`SW_OL_LSB +: 6] = {2'h0, olf[9:6]};
			end
			else
			begin
				status_word[`SW_OC_LSB +: 6] = ocf[5:0];
				status_word[`SW_OL_LSB +: 6] = olf[5:0];
			end
		end
	endfunction

	// ****************************************
	// serial frame engine
	// ****************************************
	// data valid on the falling clock edge: bits taken and shown then
	// sdi and sclk share one sync depth, so sdi has settled half a period before the fall
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			shift_r <= `CW_RESET;
			bit_cnt_r <= 8'h00;
			ctrl0_r <= `CW_RESET;
			ctrl1_r <= `CW_RESET;
			addr_r <= 1'b0;
			clr_pend_r <= 1'b0;
			clr_bank_r <= 1'b0;
			clear_r <= 2'h0;
			sdo_o <= 1'b0;
			sdo_oe_n_o <= 1'b1;
		end
		else if (init_w)
		begin
			// serial traffic ignored, banks reset
			shift_r <= `CW_RESET;
			bit_cnt_r <= 8'h00;
			ctrl0_r <= `CW_RESET;
			ctrl1_r <= `CW_RESET;
			addr_r <= 1'b0;
			clr_pend_r <= 1'b0;
			clr_bank_r <= 1'b0;
			clear_r <= 2'h0;
			sdo_o <= 1'b0;
			sdo_oe_n_o <= 1'b1;
		end
		else
		begin
			clear_r <= 2'h0;
			if (cs_fall)
			begin
				// capture diagnostics of the addressed bank
				shift_r <= status_word(addr_r, supply_fail_flag_o, thermal_warning_flag_o,
					tsd_latch_r, oc_flags, ol_flags);
				bit_cnt_r <= 8'h00;
				sdo_oe_n_o <= 1'b0;
				sdo_o <= supply_fail_flag_o; // MSB first
			end
			else if (cs_act && sclk_fall)
			begin
				// MSB out, new bit in; long frames pass through
				shift_r <= {shift_r[14:0], sdi_s_r[1]};
				bit_cnt_r <= bit_cnt_r + 8'h01;
				sdo_o <= shift_r[14]; // next bit, stands until the master's next fall
			end
			else if (cs_rise)
			begin
				sdo_oe_n_o <= 1'b1;
				// a frame off the byte grid is discarded
				if (bit_cnt_r != 8'h00 && bit_cnt_r[2:0] == 3'h0)
				begin
					// previous clear executes after this transmission
					if (clr_pend_r)
						clear_r[clr_bank_r] <= 1'b1;
					if (shift_r[`CW_BANK_BIT])
						ctrl1_r <= shift_r;
					else
						ctrl0_r <= shift_r;
					addr_r <= shift_r[`CW_BANK_BIT];
					clr_pend_r <= shift_r[`CW_CLEAR_BIT];
					clr_bank_r <= shift_r[`CW_BANK_BIT];
				end
			end
		end
	end

	// ****************************************
	// global supply and thermal supervision
	// ****************************************
	// new shutdown wins over a clear arriving the same cycle
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			supply_fail_flag_o <= 1'b0;
			thermal_warning_flag_o <= 1'b0;
			tsd_latch_r <= 1'b0;
		end
		else
		begin
			supply_fail_flag_o <= uv_s_r[1] || ov_s_r[1];
			thermal_warning_flag_o <= tw_s_r[1];
			if (tsd_s_r[1])
				tsd_latch_r <= 1'b1;
			else if (init_w || clear_r != 2'h0)
				tsd_latch_r <= 1'b0;
		end
	end

	// outputs off on supply fault or thermal shutdown; logic kept
	assign allow_w = !init_w && !uv_s_r[1] && !ov_s_r[1] && !tsd_latch_r && !tsd_s_r[1];

	// ****************************************
	// per-bridge mapping and legs
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `NUM_BRIDGES; g = g + 1)
		begin : leg
			if (g < `BANK0_BRIDGES)
			begin : b0
				assign active_w[g] = ctrl0_r[`CW_ACT0_LSB + g];
				assign level_w[g] = ctrl0_r[`CW_CONF0_LSB + g];
				assign olsd_w[g] = ctrl0_r[`CW_OLSD_BIT];
				assign clr_w[g] = clear_r[0];
			end
			else
			begin : b1
				assign active_w[g] = ctrl1_r[`CW_ACT1_LSB + g - `BANK0_BRIDGES];
				assign level_w[g] = ctrl1_r[`CW_CONF1_LSB + g - `BANK0_BRIDGES];
				assign olsd_w[g] = ctrl1_r[`CW_OLSD_BIT];
				assign clr_w[g] = clear_r[1];
			end
			bridge_leg #(
				.DEAD_CYC(DEAD_CYC),
				.OC_CYC(OC_CYC),
				.OL_CYC(OL_CYC)
			) u_leg (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.init_i(init_w),
				.allow_i(allow_w),
				.active_i(active_w[g]),
				.want_high_i(level_w[g]),
				.olsd_en_i(olsd_w[g]),
				.clear_i(clr_w[g]),
				.oc_i(oc_b_r[g]),
				.ol_i(ol_b_r[g]),
				.cross_i(cr_b_r[g]),
				.hs_on_o(hs_w[g]),
				.ls_on_o(ls_w[g]),
				.oc_flag_o(oc_flags[g]),
				.ol_flag_o(ol_flags[g])
			);
		end
	endgenerate

	// ****************************************
	// output register stage
	// ****************************************
	// kept registered; a cut on allow avoids a one-cycle overlap
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_on_o <= 10'h000;
			ls_on_o <= 10'h000;
		end
		else
		begin
			hs_on_o <= allow_w ? (hs_w & ~cr_b_r) : 10'h000;
			ls_on_o <= allow_w ? (ls_w & ~cr_b_r) : 10'h000;
		end
	end
endmodule // bridge_spi_ctrl

// [shared/bridge_ctrl_regs.vh]
// constants for the half-bridge serial fault controller
// assumes a 10 MHz system clock and an 800 ns serial clock period
`ifndef BRIDGE_CTRL_REGS_VH
`define BRIDGE_CTRL_REGS_VH

// ****************************************
// control word layout
// ****************************************
`define CW_WIDTH 16
`define CW_CLEAR_BIT 15
`define CW_BANK_BIT 14
`define CW_OLSD_BIT 13
`define CW_ACT0_LSB 7
`define CW_ACT0_MSB 12
`define CW_ACT1_LSB 7
`define CW_ACT1_MSB 10
`define CW_CONF0_LSB 1
`define CW_CONF0_MSB 6
`define CW_CONF1_LSB 1
`define CW_CONF1_MSB 4
`define CW_RESET 16'h0000

// ****************************************
// status word layout (own choice)
// ****************************************
`define SW_SUPPLY_BIT 15
`define SW_BANK_BIT 14
`define SW_TWARN_BIT 13
`define SW_TSD_BIT 12
`define SW_OC_LSB 6
`define SW_OL_LSB 0
`define BANK0_BRIDGES 6
`define BANK1_BRIDGES 4
`define NUM_BRIDGES 10

// ****************************************
// timing
// ****************************************
`define CLK_SYS_HZ 10000000
`define DEAD_TIME_NS 200
`define DEAD_CYCLES ((`DEAD_TIME_NS * (`CLK_SYS_HZ / 1000000) + 999) / 1000)
`define OC_DELAY_NS 10000
`define OC_DELAY_CYCLES ((`OC_DELAY_NS * (`CLK_SYS_HZ / 1000000) + 999) / 1000)
`define OL_DELAY_NS 100000
`define OL_DELAY_CYCLES ((`OL_DELAY_NS * (`CLK_SYS_HZ / 1000000) + 999) / 1000)

`endif

// [hw/bridge_leg.v]
// one half-bridge leg: dead time, overcurrent, open load, cross-current
// assumes fault inputs already synchronised to clk_sys_i
`timescale 1ns/1ps
`include "bridge_ctrl_regs.vh"

module bridge_leg #(
	parameter DEAD_CYC = 2,
	parameter OC_CYC = 100,
	parameter OL_CYC = 1000
) (
	input wire clk_sys_i,
	input wire rst_i,
	input wire init_i, // digital init (sleep, logic undervoltage)
	input wire allow_i, // global permission to switch
	input wire active_i, // bridge activate bit
	input wire want_high_i, // requested level when active
	input wire olsd_en_i, // open-load shutdown enable
	input wire clear_i, // one-cycle latched-fault clear
	input wire oc_i, // current above shutdown threshold
	input wire ol_i, // low-side current below reference
	input wire cross_i, // cross-current sensed
	output reg hs_on_o,
	output reg ls_on_o,
	output reg oc_flag_o,
	output reg ol_flag_o
);
	// ****************************************
	// state
	// ****************************************
	reg [15:0] dead_cnt_r; // dead-time counter
	reg [15:0] oc_cnt_r; // overcurrent filter
	reg [15:0] ol_cnt_r; // open-load filter
	reg ol_off_r; // open-load shutdown latched
	wire off_all; // any reason to keep both off
	wire tgt_hs;
	wire tgt_ls;

	assign off_all = !allow_i || !active_i || oc_flag_o || ol_off_r;
	assign tgt_hs = !off_all && want_high_i;
	assign tgt_ls = !off_all && !want_high_i;

	// ****************************************
	// switch sequencing
	// ****************************************
	// off edges are immediate; on edges wait out the dead time
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_on_o <= 1'b0;
			ls_on_o <= 1'b0;
			dead_cnt_r <= 16'h0000;
		end
		else if (!tgt_hs && !tgt_ls)
		begin
			hs_on_o <= 1'b0;
			ls_on_o <= 1'b0;
			dead_cnt_r <= 16'h0000;
		end
		else if ((tgt_hs && ls_on_o) || (tgt_ls && hs_on_o))
		begin
			// turn the other side off first, never overlap
			hs_on_o <= 1'b0;
			ls_on_o <= 1'b0;
			dead_cnt_r <= 16'h0000;
		end
		else if (!hs_on_o && !ls_on_o)
		begin
			if (dead_cnt_r >= DEAD_CYC[15:0])
			begin
				hs_on_o <= tgt_hs;
				ls_on_o <= tgt_ls;
			end
			else
				dead_cnt_r <= dead_cnt_r + 16'h0001;
		end
	end

	// ****************************************
	// latched faults
	// ****************************************
	// a new fault wins over a clear in the same cycle
	always @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			oc_cnt_r <= 16'h0000;
			ol_cnt_r <= 16'h0000;
			oc_flag_o <= 1'b0;
			ol_flag_o <= 1'b0;
			ol_off_r <= 1'b0;
		end
		else if (init_i)
		begin
			oc_cnt_r <= 16'h0000;
			ol_cnt_r <= 16'h0000;
			oc_flag_o <= 1'b0;
			ol_flag_o <= 1'b0;
			ol_off_r <= 1'b0;
		end
		else
		begin
			// overcurrent filter while a switch conducts
			if ((hs_on_o || ls_on_o) && oc_i)
				oc_cnt_r <= (oc_cnt_r < OC_CYC[15:0]) ? oc_cnt_r + 16'h0001 : oc_cnt_r;
			else
				oc_cnt_r <= 16'h0000;
			// open-load filter only for the low side in on state
			if (ls_on_o && ol_i)
				ol_cnt_r <= (ol_cnt_r < OL_CYC[15:0]) ? ol_cnt_r + 16'h0001 : ol_cnt_r;
			else
				ol_cnt_r <= 16'h0000;
			if (((hs_on_o || ls_on_o) && oc_i && oc_cnt_r >= OC_CYC[15:0]) || cross_i)
				oc_flag_o <= 1'b1;
			else if (clear_i)
				oc_flag_o <= 1'b0;
			if (ls_on_o && ol_i && ol_cnt_r >= OL_CYC[15:0])
			begin
				ol_flag_o <= 1'b1;
				ol_off_r <= olsd_en_i;
			end
			else if (clear_i)
			begin
				ol_flag_o <= 1'b0;
				ol_off_r <= 1'b0;
			end
		end
	end
endmodule // bridge_leg

// [testbench/bridge_checks_assertions.sv]
// timing checks on the ports of the serial fault controller
// assumes it is bound into bridge_spi_ctrl with one system clock
`timescale 1ns/1ps
module bridge_checks (
	input wire clk_sys_i,
	input wire rst_i,
	input wire sleep_control_input_i,
	input wire logic_uv_i,
	input wire load_uv_i,
	input wire load_ov_i,
	input wire temp_warn_i,
	input wire temp_sd_i,
	input wire [9:0] cross_i,
	input wire csn_i,
	input wire sdo_oe_n_o,
	input wire [9:0] hs_on_o,
	input wire [9:0] ls_on_o,
	input wire supply_fail_flag_o,
	input wire thermal_warning_flag_o
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// every switch off; pins are async so the windows allow for two sync flops
	wire off = (hs_on_o == 10'h000) && (ls_on_o == 10'h000);
	reset_off_a: assert property ($fell(rst_i) |-> off && sdo_oe_n_o) else $error("outputs live at reset");
	no_overlap_a: assert property ((hs_on_o & ls_on_o) == 10'h000) else $error("both switches on");
	// a direct hand-off in one cycle would mean no dead time
	no_handoff_a: assert property ((($past(hs_on_o) & ls_on_o) | ($past(ls_on_o) & hs_on_o)) == 10'h000)
		else $error("no dead time");
	sleep_off_a: assert property (!sleep_control_input_i [*6] |-> off) else $error("on in sleep");
	logic_uv_a: assert property (logic_uv_i [*6] |-> off && sdo_oe_n_o) else $error("live in logic uv");
	supply_set_a: assert property ((load_uv_i || load_ov_i) [*4] |-> supply_fail_flag_o)
		else $error("supply flag low");
	warn_follow_a: assert property ($stable(temp_warn_i) [*4] |-> thermal_warning_flag_o == temp_warn_i)
		else $error("warning flag wrong");
	tsd_off_a: assert property (temp_sd_i [*6] |-> off) else $error("on in shutdown");
	cross_off_a: assert property ((cross_i != 10'h000 && $stable(cross_i)) [*4] |->
		((hs_on_o | ls_on_o) & cross_i) == 10'h000) else $error("cross bridge on");
	select_on_a: assert property ($fell(csn_i) && sleep_control_input_i && !logic_uv_i |-> ##[1:4] !sdo_oe_n_o)
		else $error("data out not driven");
	select_off_a: assert property ($rose(csn_i) |-> ##[1:4] sdo_oe_n_o) else $error("data out not released");
endmodule // bridge_checks

bind bridge_spi_ctrl bridge_checks chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.sleep_control_input_i(sleep_control_input_i), .logic_uv_i(logic_uv_i), .load_uv_i(load_uv_i),
	.load_ov_i(load_ov_i), .temp_warn_i(temp_warn_i), .temp_sd_i(temp_sd_i), .cross_i(cross_i),
	.csn_i(csn_i), .sdo_oe_n_o(sdo_oe_n_o), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o),
	.supply_fail_flag_o(supply_fail_flag_o), .thermal_warning_flag_o(thermal_warning_flag_o));

// [testbench/spi_master_model.sv]
// serial bus master model for the controller's serial pins
// assumes a 100 ns bench clock; the link clock runs only inside frames
`timescale 1ns/1ps
module spi_master_model (
	input wire clk_i,
	input wire sdo_i, // resolved data-out wire
	output logic sclk_o,
	output logic csn_o,
	output logic sdi_o
);
	// ****************************************
	// frame engine
	// ****************************************
	initial
	begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		sdi_o = 1'b0;
	end
	// pins change only at falling bench edges
	task automatic hw(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// n bits of tx, msb first; 800 ns link period
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		hw(1);
		csn_o = 1'b0;
		hw(4);
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk_o = 1'b1;
			sdi_o = tx[i];
			hw(4);
			sclk_o = 1'b0;
			rx = {rx[30:0], sdo_i};
			hw(4);
		end
		csn_o = 1'b1;
		sdi_o = ~sdi_o; // released line has no pull, so show the inverse
		hw(6); // select high longer than 500 ns
	endtask
endmodule // spi_master_model

// [testbench/bridge_spi_ctrl_tb.sv]
// self-checking bench for the serial fault controller
// assumes the bound checker and the master model beside the design
`timescale 1ns/1ps
module bridge_spi_ctrl_tb;
	// ****************************************
	// wiring and stimulus
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic slp = 1'b1; // sleep pin, high keeps awake
	logic luv = 1'b0;
	logic suv = 1'b0;
	logic sov = 1'b0;
	logic twi = 1'b0;
	logic tsd = 1'b0;
	logic [9:0] oc = 10'h000;
	logic [9:0] ol = 10'h000;
	logic [9:0] cr = 10'h000;
	logic sclk, csn, sdi;
	wire sdo, oe, sf, tw;
	wire [9:0] hs, ls;
	wire [19:0] drv = {hs, ls};
	wire [11:0] b0 = {hs[5:0], ls[5:0]};
	wire sdo_w = oe ? ~sdo : sdo; // released wire shows the inverse level
	logic [31:0] rx;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	always #50 clk = ~clk;
	// short fault filters keep the run brief
	bridge_spi_ctrl #(.DEAD_CYC(2), .OC_CYC(3), .OL_CYC(5)) dut (.clk_sys_i(clk), .rst_i(rst),
		.sleep_control_input_i(slp), .logic_uv_i(luv), .load_uv_i(suv), .load_ov_i(sov),
		.temp_warn_i(twi), .temp_sd_i(tsd), .oc_i(oc), .ol_i(ol), .cross_i(cr), .sclk_i(sclk),
		.csn_i(csn), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(oe), .hs_on_o(hs), .ls_on_o(ls),
		.supply_fail_flag_o(sf), .thermal_warning_flag_o(tw));
	spi_master_model m (.clk_i(clk), .sdo_i(sdo_w), .sclk_o(sclk), .csn_o(csn), .sdi_o(sdi));
	// ****************************************
	// tasks
	// ****************************************
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic fr(input int n, input logic [31:0] tx);
		m.xfer(n, tx, rx);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, far above the expected few thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		wt(10);
		rst = 1'b0;
		wt(5);
		chk("drv", drv, 0);
		fr(16, 16'h1faa);
		chk("st", rx, 16'h0000);
		fr(16, 16'h4794);
		wt(6);
		chk("drv", drv, {4'ha, 6'h15, 4'h5, 6'h2a});
		fr(16, 16'h1fd4);
		chk("st1", rx, 16'h4000);
		$display("test access done");
		wt(8);
		chk("b0", b0, 12'ha95);
		oc[0] = 1'b1;
		ol[2] = 1'b1;
		wt(20);
		oc = 10'h000;
		ol = 10'h000;
		chk("ls", ls[5:0], 6'h14);
		fr(16, 16'h3fd4);
		ol[4] = 1'b1;
		wt(20);
		ol = 10'h000;
		chk("st", rx, 16'h0044);
		chk("ls", ls[5:0], 6'h04);
		fr(16, 16'hbfd4);
		chk("st", rx, 16'h0054);
		fr(16, 16'h3fd4);
		chk("st", rx, 16'h0054);
		fr(16, 16'h3fd4);
		chk("st", rx, 16'h0000);
		chk("b0", b0, 12'ha95);
		$display("test faults done");
		for (int k = 0; k < 2; k++)
		begin
			suv = (k == 0);
			sov = (k == 1);
			wt(6);
			chk("sf", sf, 1);
			chk("drv", drv, 0);
			fr(16, 16'h3fd4);
			chk("st", rx, 16'h8000);
			suv = 1'b0;
			sov = 1'b0;
			wt(8);
			chk("sf", sf, 0);
			chk("b0", b0, 12'ha95);
		end
		$display("test supply done");
		twi = 1'b1;
		wt(6);
		fr(16, 16'h3fd4);
		chk("st", rx, 16'h2000);
		twi = 1'b0;
		wt(6);
		chk("tw", tw, 0);
		tsd = 1'b1;
		wt(6);
		tsd = 1'b0;
		wt(6);
		chk("drv", drv, 0);
		fr(16, 16'hbfd4);
		chk("st", rx, 16'h1000);
		fr(16, 16'h3fd4);
		wt(8);
		chk("b0", b0, 12'ha95);
		$display("test thermal done");
		cr[6] = 1'b1;
		wt(6);
		cr = 10'h000;
		wt(3);
		chk("b7", {hs[6], ls[6]}, 0);
		fr(16, 16'h4794);
		fr(16, 16'h4794);
		chk("st1", rx, 16'h4040);
		$display("test cross done");
		fr(12, 32'h000);
		wt(6);
		chk("b0", b0, 12'ha95);
		fr(24, 32'ha53faa);
		chk("pass", rx[7:0], 8'ha5);
		chk("oe", oe, 1);
		wt(6);
		chk("hs", hs[5:0], 6'h15);
		$display("test framing done");
		slp = 1'b0;
		wt(6);
		chk("drv", drv, 0);
		slp = 1'b1;
		wt(6);
		chk("drv", drv, 0);
		luv = 1'b1;
		wt(6);
		fr(16, 16'h1faa);
		luv = 1'b0;
		wt(8);
		chk("drv", drv, 0);
		fr(16, 16'h1faa);
		chk("st", rx, 16'h0000);
		wt(6);
		chk("hs", hs[5:0], 6'h15);
		$display("test sleep done");
		tally_and_finish;
	end
endmodule // bridge_spi_ctrl_tb
